/* core/ard_pkg.sv */
// shared constants, enumerations and carriers for the auxiliary ram decode block
package ard_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0]  CHIP_CONTROL_IDX  = 8'h9f;  // chip control
  localparam logic [7:0]  AUX_UPPER_IDX     = 8'ha1;  // aux ram high address
  localparam logic [7:0]  TA_IDX            = 8'hc7;  // timed access key register
  localparam logic [7:0]  STATUS_IDX        = 8'hc8;  // block status, read only
  // chip control layout
  localparam int          ENABLE_BIT        = 4;      // aux_ram_enable position
  localparam logic [7:0]  CTRL_RESET        = 8'h10;  // enable set after every reset
  localparam logic [7:0]  CTRL_WMASK        = 8'hf3;  // bits 3:2 reserved
  localparam logic [7:0]  CTRL_RMASK        = 8'h73;  // bit 7 is write only
  // high address register layout
  localparam logic [7:0]  UPPER_RESET       = 8'h00;
  localparam logic [7:0]  UPPER_MASK        = 8'h03;  // bits 7:2 reserved
  // timed access keys
  localparam logic [7:0]  TA_KEY1           = 8'haa;
  localparam logic [7:0]  TA_KEY2           = 8'h55;
  // address map
  localparam logic [15:0] AUX_LAST_ADDR     = 16'h03ff;
  localparam int          AUX_WORDS         = 1024;
  // external strobe timing
  localparam int          CLK_PERIOD_NS     = 50;
  localparam int          STROBE_NS         = 150;    // least strobe width
  localparam int          STROBE_CYCLES     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  STROBE_LAST       = 4'(STROBE_CYCLES - 1);

  // how the core forms the address of an external move
  typedef enum logic [1:0] {
    KIND_DATA_POINTER,
    KIND_INDIRECT,
    KIND_STACK
  } ard_kind_type;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INT,
    ST_ADDR,
    ST_STROBE
  } ard_fsm_type;

  // request from the core, held until ack
  typedef struct packed {
    logic         valid;
    ard_kind_type kind;
    logic         write;
    logic [15:0]  data_pointer;   // data_pointer value
    logic [7:0]   ri;     // indirect_index_register value
    logic [7:0]   wdata;
  } ard_core_req_type;

  // answer to the core
  typedef struct packed {
    logic         ack;
    logic         internal;
    logic [7:0]   rdata;
  } ard_core_rsp_type;

  // external memory bus pins
  typedef struct packed {
    logic [7:0]   lad_out;  // low_address_data_port drive value
    logic         lad_oe;
    logic [7:0]   hi_addr;  // high_address_port
    logic         ale;
    logic         wr_n;
    logic         rd_n;
  } ard_ext_bus_type;
endpackage : ard_pkg

/* core/ard_top.sv */
// auxiliary ram array, access steering and its control registers
// What this block does
// - 1024-byte internal ram at 000H to 3FFH
// - ram enabled after every reset
// - ram reached only by external moves
// - indirect moves stay internal while enabled
// - pointer above 03FFH always goes external
// - chip control writable only after timed access
// - internal access leaves pins and strobes idle
// - stack accesses never reach the ram
// - high address bits 1:0 form address 9:8
// - high address register resets to zero
// - control bit 4 enables internal ram
`timescale 1ns/1ps
module ard_top #(
  parameter int WORDS = ard_pkg::AUX_WORDS   // array depth
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [31:0]               wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // core external move port
  input  wire ard_pkg::ard_core_req_type core_req,
  output ard_pkg::ard_core_rsp_type      core_rsp,
  // external memory bus
  input  wire logic [7:0]                lad_in,
  output ard_pkg::ard_ext_bus_type       ext_bus
);

  // whole block state in one record, except the array and its read data mem_q
  typedef struct packed {
    ard_pkg::ard_fsm_type     fsm;
    logic [7:0]               ctrl;      // chip_control
    logic [7:0]               upper;     // aux_ram_high_address
    logic [1:0]               ta_stage;  // 0 idle, 1 first key, 2 armed
    logic [3:0]               cnt;       // strobe countdown
    logic [7:0]               sync1;     // first stage, read only by sync2
    logic [7:0]               sync2;
    logic                     last_int;  // last access served inside
    logic                     wb_ack;
    logic [31:0]              wb_dat;
    ard_pkg::ard_core_rsp_type rsp;
    ard_pkg::ard_ext_bus_type  bus;
  } ard_state_type;

  localparam ard_state_type RESET_STATE = '{
    fsm:      ard_pkg::ST_IDLE,
    ctrl:     ard_pkg::CTRL_RESET,
    upper:    ard_pkg::UPPER_RESET,
    ta_stage: 2'h0,
    cnt:      4'h0,
    sync1:    8'h00,
    sync2:    8'h00,
    last_int: 1'b0,
    wb_ack:   1'b0,
    wb_dat:   32'h0000_0000,
    rsp:      '0,
    bus:      '{lad_out: 8'h00, lad_oe: 1'b0, hi_addr: 8'h00,
                ale: 1'b0, wr_n: 1'b1, rd_n: 1'b1}
  };

  ard_state_type s_q;                     // registered state
  ard_state_type s_d;                     // next state
  logic [7:0]    mem [WORDS];             // the auxiliary array
  logic [7:0]    mem_q;                   // synchronous read data
  logic [9:0]    mem_addr;                // array index of the request
  logic          accept;                  // new core request taken now
  logic          go_int;                  // taken request is served inside
  logic          mem_we;                  // array write strobe
  logic          wb_req;                  // new bus access this cycle
  logic          wb_wr;                   // bus write with low lane enabled
  logic [7:0]    wb_idx;                  // register index
  logic          wb_map;                  // upper address bits clear

  // steering decision, shared by the sequencer and the checks
  function automatic logic route_internal(input ard_pkg::ard_core_req_type r,
                                          input logic en);
    case (r.kind)
      ard_pkg::KIND_DATA_POINTER:     route_internal = en && (r.data_pointer <= ard_pkg::AUX_LAST_ADDR);
      ard_pkg::KIND_INDIRECT: route_internal = en;
      default:                route_internal = 1'b0;
    endcase
  endfunction : route_internal

  // array index: pointer low bits, or high register over the indirect byte
  always_comb begin
    if (core_req.kind == ard_pkg::KIND_INDIRECT) begin
      mem_addr = {s_q.upper[1:0], core_req.ri};
    end else begin
      mem_addr = core_req.data_pointer[9:0];
    end
  end

  assign accept = (s_q.fsm == ard_pkg::ST_IDLE) && core_req.valid && !s_q.rsp.ack;
  assign go_int = route_internal(core_req, s_q.ctrl[ard_pkg::ENABLE_BIT]);
  // only the core move port can write the array, never the register bus
  assign mem_we = accept && go_int && core_req.write;

  assign wb_req = wb_cyc_i && wb_stb_i && !s_q.wb_ack;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
  assign wb_idx = wb_adr_i[9:2];
  assign wb_map = (wb_adr_i[31:10] == 22'h0);

  // array port kept apart from the state record: a memory does not fit a packed struct
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_addr] <= core_req.wdata;
    end
    mem_q <= mem[mem_addr];
  end

  // next-state logic for registers, bus slave and access sequencer
  always_comb begin
    s_d = s_q;
    // pin input crosses two flops before use
    s_d.sync1 = lad_in;
    s_d.sync2 = s_q.sync1;
    // answers are single-cycle pulses
    s_d.rsp.ack = 1'b0;
    s_d.wb_ack  = wb_req;

    // register reads; unmapped and reserved bits return zero
    s_d.wb_dat = 32'h0000_0000;
    if (wb_req && wb_map) begin
      case (wb_idx)
        ard_pkg::CHIP_CONTROL_IDX: s_d.wb_dat[7:0] = s_q.ctrl & ard_pkg::CTRL_RMASK;
        ard_pkg::AUX_UPPER_IDX:    s_d.wb_dat[7:0] = s_q.upper;
        ard_pkg::STATUS_IDX:       s_d.wb_dat[7:0] = {3'h0, s_q.last_int,
                                     s_q.fsm != ard_pkg::ST_IDLE, 1'b0, s_q.ta_stage};
        default:                   s_d.wb_dat = 32'h0000_0000;
      endcase
    end

    // register writes and the timed access unlock
    if (wb_wr && wb_map) begin
      // any write other than a key step drops the unlock
      s_d.ta_stage = 2'h0;
      case (wb_idx)
        ard_pkg::TA_IDX: begin
          if (wb_dat_i[7:0] == ard_pkg::TA_KEY1) begin
            s_d.ta_stage = 2'h1;
          end else if (s_q.ta_stage == 2'h1 && wb_dat_i[7:0] == ard_pkg::TA_KEY2) begin
            s_d.ta_stage = 2'h2;
          end
        end
        ard_pkg::CHIP_CONTROL_IDX: begin
          // unprotected writes are silently dropped
          if (s_q.ta_stage == 2'h2) begin
            s_d.ctrl = wb_dat_i[7:0] & ard_pkg::CTRL_WMASK;
          end
        end
        ard_pkg::AUX_UPPER_IDX: begin
          s_d.upper = wb_dat_i[7:0] & ard_pkg::UPPER_MASK;
        end
        default: begin
          s_d.ta_stage = 2'h0;
        end
      endcase
    end

    // access sequencer
    case (s_q.fsm)
      ard_pkg::ST_IDLE: begin
        if (accept) begin
          if (core_req.kind == ard_pkg::KIND_STACK) begin
            // stack lives in core memory; answer without touching anything
            s_d.rsp.ack      = 1'b1;
            s_d.rsp.internal = 1'b0;
            s_d.rsp.rdata    = 8'h00;
          end else if (go_int) begin
            s_d.fsm = ard_pkg::ST_INT;
          end else begin
            // address phase: low byte on the shared port, latched by ale
            s_d.fsm         = ard_pkg::ST_ADDR;
            s_d.bus.ale     = 1'b1;
            s_d.bus.lad_oe  = 1'b1;
            s_d.bus.lad_out = (core_req.kind == ard_pkg::KIND_DATA_POINTER) ?
                              core_req.data_pointer[7:0] : core_req.ri;
            s_d.bus.hi_addr = (core_req.kind == ard_pkg::KIND_DATA_POINTER) ?
                              core_req.data_pointer[15:8] : s_q.upper;
          end
        end
      end
      ard_pkg::ST_INT: begin
        // pins stay quiet; data comes from the array read of last cycle
        s_d.fsm          = ard_pkg::ST_IDLE;
        s_d.rsp.ack      = 1'b1;
        s_d.rsp.internal = 1'b1;
        s_d.rsp.rdata    = core_req.write ? 8'h00 : mem_q;
        s_d.last_int     = 1'b1;
      end
      ard_pkg::ST_ADDR: begin
        // strobe phase: drive write data or release the port for a read
        s_d.fsm     = ard_pkg::ST_STROBE;
        s_d.cnt     = ard_pkg::STROBE_LAST;
        s_d.bus.ale = 1'b0;
        if (core_req.write) begin
          s_d.bus.wr_n    = 1'b0;
          s_d.bus.lad_out = core_req.wdata;
        end else begin
          s_d.bus.rd_n   = 1'b0;
          s_d.bus.lad_oe = 1'b0;
        end
      end
      ard_pkg::ST_STROBE: begin
        if (s_q.cnt == 4'h0) begin
          // sampling the synchroniser output costs two cycles of setup
          s_d.fsm          = ard_pkg::ST_IDLE;
          s_d.bus.wr_n     = 1'b1;
          s_d.bus.rd_n     = 1'b1;
          s_d.bus.lad_oe   = 1'b0;
          s_d.rsp.ack      = 1'b1;
          s_d.rsp.internal = 1'b0;
          s_d.rsp.rdata    = core_req.write ? 8'h00 : s_q.sync2;
          s_d.last_int     = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: begin
        s_d.fsm = ard_pkg::ST_IDLE;
      end
    endcase
  end

  // state register; synchronous reset restores enable and clears high address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // every output straight from the state record
  assign wb_dat_o = s_q.wb_dat;
  assign wb_ack_o = s_q.wb_ack;
  assign core_rsp = s_q.rsp;
  assign ext_bus  = s_q.bus;

  // checks
  sequence seq_strobe;
    (!s_q.bus.wr_n || !s_q.bus.rd_n) [*3];
  endsequence

  sequence seq_quiet;
    !s_q.bus.ale && s_q.bus.wr_n && s_q.bus.rd_n && !s_q.bus.lad_oe;
  endsequence

  // address phase as the pins show it
  sequence seq_addr_phase;
    s_q.fsm == ard_pkg::ST_ADDR && s_q.bus.ale && s_q.bus.lad_oe;
  endsequence

  a_enable_after_reset: assert property (@(posedge clk)
    !$past(rst_n) && rst_n |-> s_q.ctrl[ard_pkg::ENABLE_BIT])
    else $error("aux ram not enabled after reset");

  a_upper_after_reset: assert property (@(posedge clk)
    !$past(rst_n) && rst_n |-> s_q.upper == 8'h00)
    else $error("high address not zero after reset");

  a_upper_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.upper[7:2] == 6'h00)
    else $error("reserved high address bits set");

  a_low_range_internal: assert property (@(posedge clk) disable iff (!rst_n)
    accept && core_req.kind == ard_pkg::KIND_DATA_POINTER && s_q.ctrl[ard_pkg::ENABLE_BIT]
    && core_req.data_pointer <= 16'h03ff |=> s_q.fsm == ard_pkg::ST_INT ##1 s_q.rsp.ack)
    else $error("low pointer access not served inside");

  a_high_ptr_external: assert property (@(posedge clk) disable iff (!rst_n)
    accept && core_req.kind == ard_pkg::KIND_DATA_POINTER && core_req.data_pointer > 16'h03ff
    |=> s_q.fsm == ard_pkg::ST_ADDR && s_q.bus.ale && s_q.bus.hi_addr == $past(core_req.data_pointer[15:8]))
    else $error("high pointer access not external");

  a_indirect_internal: assert property (@(posedge clk) disable iff (!rst_n)
    accept && core_req.kind == ard_pkg::KIND_INDIRECT && s_q.ctrl[ard_pkg::ENABLE_BIT]
    |=> s_q.fsm == ard_pkg::ST_INT)
    else $error("indirect access escaped while enabled");

  a_disabled_external: assert property (@(posedge clk) disable iff (!rst_n)
    accept && core_req.kind != ard_pkg::KIND_STACK && !s_q.ctrl[ard_pkg::ENABLE_BIT]
    |=> s_q.fsm == ard_pkg::ST_ADDR ##1 seq_strobe ##1 s_q.rsp.ack && !s_q.rsp.internal)
    else $error("disabled access did not run external cycle");

  a_ctrl_protected: assert property (@(posedge clk) disable iff (!rst_n)
    wb_wr && wb_map && wb_idx == ard_pkg::CHIP_CONTROL_IDX && s_q.ta_stage != 2'h2
    |=> $stable(s_q.ctrl))
    else $error("chip control changed without timed access");

  a_internal_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    accept && go_int |=> seq_quiet [*2])
    else $error("pins moved during internal access");

  a_stack_untouched: assert property (@(posedge clk) disable iff (!rst_n)
    accept && core_req.kind == ard_pkg::KIND_STACK
    |-> !mem_we ##1 ((s_q.fsm == ard_pkg::ST_IDLE && s_q.rsp.ack) and seq_quiet))
    else $error("stack access reached the ram or pins");

  a_array_move_only: assert property (@(posedge clk) disable iff (!rst_n)
    mem_we |-> core_req.valid && core_req.kind != ard_pkg::KIND_STACK
    && s_q.fsm == ard_pkg::ST_IDLE)
    else $error("array written outside an external move");

  // a strobe shorter than the minimum would be missed by slow memory
  a_strobe_width: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(s_q.bus.rd_n) || $fell(s_q.bus.wr_n)
    |-> seq_strobe ##1 (s_q.bus.wr_n && s_q.bus.rd_n))
    else $error("external strobe width wrong");

  a_write_drives_port: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.bus.wr_n |-> s_q.bus.lad_oe && s_q.bus.rd_n)
    else $error("write strobe without port drive");

  a_read_port_free: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.bus.rd_n |-> !s_q.bus.lad_oe && s_q.bus.wr_n)
    else $error("port driven during read strobe");

  a_indirect_high_byte: assert property (@(posedge clk) disable iff (!rst_n)
    accept && core_req.kind == ard_pkg::KIND_INDIRECT && !s_q.ctrl[ard_pkg::ENABLE_BIT]
    |=> seq_addr_phase and (s_q.bus.hi_addr == $past(s_q.upper)
    && s_q.bus.lad_out == $past(core_req.ri)))
    else $error("indirect external address wrong");

  a_ctrl_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.ctrl[3:2] == 2'h0)
    else $error("reserved chip control bits set");

  a_unlock_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
    wb_wr && wb_map && s_q.ta_stage == 2'h2 |=> s_q.ta_stage != 2'h2)
    else $error("timed access stayed armed");

  a_internal_answer: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.fsm == ard_pkg::ST_INT |=> (s_q.rsp.ack && s_q.rsp.internal) and seq_quiet)
    else $error("internal answer wrong or pins moved");

  a_answer_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.rsp.ack |=> !s_q.rsp.ack)
    else $error("move answer longer than one cycle");

endmodule : ard_top

/* tb/ard_core_model.sv */
// behavioural processor core issuing external moves to the decode block
`timescale 1ns/1ps
module ard_core_model (
  input  wire logic                      clk,
  input  wire ard_pkg::ard_core_rsp_type core_rsp,
  output ard_pkg::ard_core_req_type      core_req
);
  // idle until the first move
  initial core_req = '0;

  // one move: fields held until ack is sampled, then released scrambled
  task automatic access(input ard_pkg::ard_kind_type k, input logic w,
                        input logic [15:0] dp, input logic [7:0] ix,
                        input logic [7:0] wd, output logic [7:0] rd,
                        output logic inl, output int lat);
    lat = 0;
    @(posedge clk);
    core_req <= '{valid: 1'b1, kind: k, write: w, data_pointer: dp, ri: ix, wdata: wd};
    do begin
      @(posedge clk);
      lat++;
    end while (core_rsp.ack !== 1'b1);
    rd  = core_rsp.rdata;
    inl = core_rsp.internal;
    // released fields must not look like the old request
    core_req <= '{valid: 1'b0, kind: k, write: ~w, data_pointer: ~dp, ri: ~ix, wdata: ~wd};
  endtask : access
endmodule : ard_core_model

/* tb/tb.sv */
// self-checking bench for the auxiliary ram decode block
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] A_CTL = {22'h0, ard_pkg::CHIP_CONTROL_IDX, 2'b00};
  localparam logic [31:0] A_HI  = {22'h0, ard_pkg::AUX_UPPER_IDX, 2'b00};
  localparam logic [31:0] A_TA  = {22'h0, ard_pkg::TA_IDX, 2'b00};
  localparam logic [31:0] A_ST  = {22'h0, ard_pkg::STATUS_IDX, 2'b00};
  // latencies count edges up to the one that samples ack high
  localparam int LAT_STK = 2;
  localparam int LAT_INT = 3;
  localparam int LAT_EXT = 3 + ard_pkg::STROBE_CYCLES;
  logic                      clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack_o;
  logic [31:0]               wb_adr, wb_dat, wb_dat_o;
  logic [3:0]                wb_sel;
  logic [7:0]                lad_in, rd, ale_lo, wr_dat;
  ard_pkg::ard_core_req_type core_req;
  ard_pkg::ard_core_rsp_type core_rsp;
  ard_pkg::ard_ext_bus_type  ext_bus;
  logic                      inl;
  int                        lat, n_fail, samples_checked, pin_ev, wr_low;

  ard_top dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_req(core_req),
    .core_rsp(core_rsp), .lad_in(lad_in), .ext_bus(ext_bus));
  ard_core_model core_u (.clk(clk), .core_rsp(core_rsp), .core_req(core_req));

  // external memory answers c3 while read strobe is low, inverse otherwise
  assign lad_in = ext_bus.rd_n ? 8'h3c : 8'hc3;
  // pin activity monitor; idle pins keep both counts still
  always @(posedge clk) begin
    if (ext_bus.ale === 1'b1 || ext_bus.rd_n !== 1'b1 || ext_bus.wr_n !== 1'b1)
      pin_ev++;
    if (ext_bus.wr_n === 1'b0)
      wr_low++;
    // low address byte latched by ale, data seen under the write strobe
    if (ext_bus.ale === 1'b1)
      ale_lo <= ext_bus.lad_out;
    if (ext_bus.wr_n === 1'b0)
      wr_dat <= ext_bus.lad_out;
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chkn(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  // one classic wishbone cycle; ack must be sampled two edges after start
  task automatic wb(input logic we, input logic [31:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= {24'h0000_00, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chkn(n, 2);
    @(posedge clk);
  endtask : wb
  task automatic mv(input ard_pkg::ard_kind_type k, input logic w, input logic [15:0] dp,
                    input logic [7:0] ix, input logic [7:0] wd);
    core_u.access(k, w, dp, ix, wd, rd, inl, lat);
  endtask : mv
  // unlock chip control for exactly one write
  task automatic ta_unlock;
    wb(1'b1, A_TA, ard_pkg::TA_KEY1);
    wb(1'b1, A_TA, ard_pkg::TA_KEY2);
  endtask : ta_unlock

  task automatic t_reset;
    wb(1'b0, A_CTL, 8'h00);
    chk8(rd, 8'h10);
    wb(1'b0, A_HI, 8'h00);
    chk8(rd, 8'h00);
    wb(1'b1, A_HI, 8'hff);
    wb(1'b0, A_HI, 8'h00);
    chk8(rd, 8'h03);
  endtask : t_reset
  task automatic t_internal;
    int p;
    p = pin_ev;
    mv(ard_pkg::KIND_DATA_POINTER, 1'b1, 16'h03ff, 8'h00, 8'h5a);
    chkn(lat, LAT_INT);
    mv(ard_pkg::KIND_INDIRECT, 1'b0, 16'h0000, 8'hff, 8'h00);
    chk8(rd, 8'h5a);
    chk8({7'h0, inl}, 8'h01);
    wb(1'b1, A_HI, 8'h01);
    mv(ard_pkg::KIND_INDIRECT, 1'b1, 16'h0000, 8'h23, 8'h77);
    mv(ard_pkg::KIND_DATA_POINTER, 1'b0, 16'h0123, 8'h00, 8'h00);
    chk8(rd, 8'h77);
    chkn(pin_ev - p, 0);
    wb(1'b0, A_ST, 8'h00);
    chk8(rd, 8'h10);
  endtask : t_internal
  task automatic t_external;
    int w;
    w = wr_low;
    mv(ard_pkg::KIND_DATA_POINTER, 1'b1, 16'h0400, 8'h00, 8'ha5);
    chkn(lat, LAT_EXT);
    chkn(wr_low - w, ard_pkg::STROBE_CYCLES);
    chk8(ext_bus.hi_addr, 8'h04);
    chk8(wr_dat, 8'ha5);
    chk8(ale_lo, 8'h00);
    mv(ard_pkg::KIND_DATA_POINTER, 1'b0, 16'hffff, 8'h00, 8'h00);
    chk8(rd, 8'hc3);
    chk8(ale_lo, 8'hff);
    chk8({7'h0, inl}, 8'h00);
  endtask : t_external
  task automatic t_enable;
    wb(1'b1, A_CTL, 8'h00);
    wb(1'b0, A_CTL, 8'h00);
    chk8(rd, 8'h10);
    ta_unlock();
    wb(1'b0, A_ST, 8'h00);
    chk8(rd, 8'h02);
    wb(1'b1, A_CTL, 8'h00);
    wb(1'b0, A_CTL, 8'h00);
    chk8(rd, 8'h00);
    mv(ard_pkg::KIND_DATA_POINTER, 1'b0, 16'h0010, 8'h00, 8'h00);
    chk8(rd, 8'hc3);
    chkn(lat, LAT_EXT);
    mv(ard_pkg::KIND_INDIRECT, 1'b0, 16'h0000, 8'h23, 8'h00);
    chk8(ext_bus.hi_addr, 8'h01);
    chk8(ale_lo, 8'h23);
    chk8({7'h0, inl}, 8'h00);
    ta_unlock();
    wb(1'b1, A_CTL, 8'h10);
    mv(ard_pkg::KIND_DATA_POINTER, 1'b0, 16'h0123, 8'h00, 8'h00);
    chk8(rd, 8'h77);
  endtask : t_enable
  task automatic t_stack_unmapped;
    int p;
    p = pin_ev;
    mv(ard_pkg::KIND_STACK, 1'b0, 16'h0123, 8'h23, 8'h00);
    chkn(lat, LAT_STK);
    chk8(rd, 8'h00);
    chkn(pin_ev - p, 0);
    // alias of the high address register above the map must not reach it
    wb(1'b1, 32'h0000_0684, 8'hff);
    wb(1'b0, 32'h0000_0684, 8'h00);
    chk8(rd, 8'h00);
    wb(1'b0, A_HI, 8'h00);
    chk8(rd, 8'h01);
  endtask : t_stack_unmapped
  // reset in mid-run with the ram disabled and high address set
  task automatic t_reset_again;
    ta_unlock();
    wb(1'b1, A_CTL, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, A_CTL, 8'h00);
    chk8(rd, 8'h10);
    wb(1'b0, A_HI, 8'h00);
    chk8(rd, 8'h00);
    mv(ard_pkg::KIND_DATA_POINTER, 1'b0, 16'h0123, 8'h00, 8'h00);
    chk8({7'h0, inl}, 8'h01);
  endtask : t_reset_again

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  // watchdog sized well above the roughly 140 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  // main sequence
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    {n_fail, samples_checked, pin_ev, wr_low} = '0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_internal();
    t_external();
    t_enable();
    t_stack_unmapped();
    t_reset_again();
    give_verdict();
  end
endmodule : tb
